// ### rtl/hcer_pkg.sv
// hcer_pkg: constants and carrier types of the host control register bank
// assumes: byte-wide host port, serial nonvolatile memory behind the bank
package hcer_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_CONTROL = 5'h00; // reset / memory control
  localparam logic [4:0] OFS_NVCTL = 5'h01; // nonvolatile control
  localparam logic [4:0] OFS_HWSUP = 5'h04; // hardware support
  localparam logic [4:0] OFS_SWITCHED = 5'h08; // first switched offset

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_ENG_RESET = 7; // engine soft reset
  localparam int BIT_MEM_ENABLE = 6; // shared memory enable
  localparam int BIT_STORE = 7; // store request
  localparam int BIT_RECALL = 6; // recall request
  localparam int BIT_BANK_TOP = 5; // resource string select
  localparam int BIT_UNLOCK = 4; // unlock
  localparam int BIT_SWITCH = 7; // bank switch in support reg

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CONTROL = 8'h80;
  localparam logic [4:0] RST_BANK = 5'h06;
  localparam logic [7:0] RST_HWSUP = 8'h00;
  localparam logic [3:0] JUMPER_INIT_CODE = 4'h9;

  // ----------------------------------------------------------------
  // timing: RECALL_CYCLES is 2 ms at 25 MHz; the engine recalls in 64 serial bit times
  // ----------------------------------------------------------------
  localparam int RECALL_TIME_US = 2000;
  localparam int CLK_MHZ = 25;
  localparam int RECALL_CYCLES = RECALL_TIME_US * CLK_MHZ;
  localparam int NV_BIT_CYCLES = 4; // serial bit time, in clocks

  // carrier to the serial memory engine
  typedef struct packed {
    logic start; // one-cycle pulse
    logic write; // 1 store, 0 recall
    logic [4:0] bank; // bank address
    logic cfg; // recall into config group
  } hcer_nvreq_t;

  typedef enum logic [1:0] {
    NV_IDLE = 2'b00,
    NV_BUSY = 2'b01,
    NV_DONE = 2'b11
  } hcer_nvst_t;

endpackage : hcer_pkg

// ### rtl/hcer_nvmem.sv
// hcer_nvmem: serial nonvolatile memory engine, 8 bytes per bank
// assumes: requests come only while idle; array models the part's cells
`timescale 1ns/1ns
module hcer_nvmem (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request
  input hcer_pkg::hcer_nvreq_t req,
  input wire logic [63:0] wdata,
  // answer
  output logic busy,
  output logic done,
  output logic [63:0] rdata
);
  // ----------------------------------------------------------------
  // storage and sequencing
  // ----------------------------------------------------------------
  logic [63:0] cells [0:31]; // one 8-byte slot per bank
  hcer_pkg::hcer_nvst_t st_reg;
  logic [9:0] cnt_reg; // bit timer, 64 bits serial
  logic wr_reg;
  logic [4:0] bank_reg;
  wire last = (cnt_reg == 10'(64 * hcer_pkg::NV_BIT_CYCLES - 1));

  // state sequencing; serial time imitated by a counter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= hcer_pkg::NV_IDLE;
      cnt_reg <= 10'h000;
      wr_reg <= 1'b0;
      bank_reg <= 5'h00;
    end else begin
      case (st_reg)
        hcer_pkg::NV_IDLE: begin
          cnt_reg <= 10'h000;
          if (req.start) begin
            st_reg <= hcer_pkg::NV_BUSY;
            wr_reg <= req.write;
            bank_reg <= req.bank;
          end
        end
        hcer_pkg::NV_BUSY: begin
          cnt_reg <= cnt_reg + 10'h001;
          if (last) st_reg <= hcer_pkg::NV_DONE;
        end
        default: st_reg <= hcer_pkg::NV_IDLE;
      endcase
    end
  end

  // cell write at the end of a store; no reset on memory
  always_ff @(posedge clk) begin
    if (st_reg == hcer_pkg::NV_BUSY && last && wr_reg)
      cells[bank_reg] <= wdata;
  end

  assign rdata = cells[bank_reg];
  assign busy = (st_reg != hcer_pkg::NV_IDLE);
  assign done = (st_reg == hcer_pkg::NV_DONE);
endmodule : hcer_nvmem

// ### rtl/hcer_bufaddr.sv
// hcer_bufaddr: shared buffer address former
// assumes: host address and base come from the host bus decoder
`timescale 1ns/1ns
module hcer_bufaddr (
  // host side
  input wire logic [19:0] host_system_address,
  input wire logic [19:0] base_addr,
  input wire logic [2:0] page_offset,
  input wire logic mem_enable,
  // buffer side
  output logic [15:0] buf_addr,
  output logic buf_sel
);
  // ----------------------------------------------------------------
  // offset into window plus page offset in 8 kB pages
  // ----------------------------------------------------------------
  wire [19:0] diff = host_system_address - base_addr;
  assign buf_addr = diff[15:0] + {page_offset, 13'h0000};
  assign buf_sel = mem_enable;
endmodule : hcer_bufaddr

// ### rtl/hcer_regs.sv
// hcer_regs: host control register bank with nonvolatile control
// assumes: byte host port on MCLK, jumpers async pins, engine downstream
`timescale 1ns/1ns
module hcer_regs (
  // clock and reset
  input wire logic MCLK,
  input wire logic RSTN,
  // host register port
  input wire logic [4:0] ADDR,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] WDATA,
  output logic [7:0] RDATA,
  // jumpers (asynchronous pins)
  input wire logic [3:0] INIT_JUMPER_LEVELS,
  // shared memory path
  input wire logic [19:0] HOST_SYSTEM_ADDRESS,
  input wire logic [19:0] BUF_BASE,
  output logic [15:0] BUF_ADDR,
  output logic BUF_SEL,
  // engine control
  output logic ENGINE_RESET,
  output logic NV_BUSY,
  output logic RESOURCE_AREA
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] control_reg; // reset / memory control
  logic store_reg, recall_reg; // self-clearing request bits
  logic unlock_reg; // unlock control
  logic [4:0] bank_reg; // nonvolatile bank select
  logic [7:0] hwsup_reg; // only the switch bit stored
  logic [7:0] addr_grp [0:7]; // station address group
  logic [7:0] cfg_grp [0:7]; // board configuration group
  logic [3:0] jmp_s1_reg, jmp_s2_reg; // jumper synchroniser
  logic [1:0] arm_reg; // unlock arming progress
  logic init_pend_reg; // initial recall outstanding
  logic cfg_dest_reg; // recall lands in config group
  logic init_chk_reg; // first cycle after reset release
  logic engine_reset_reg;
  logic [7:0] rdata_reg;
  logic [15:0] bufaddr_reg;
  logic bufsel_reg;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire wr_ctl = WR && ADDR == hcer_pkg::OFS_CONTROL;
  wire wr_nv = WR && ADDR == hcer_pkg::OFS_NVCTL;
  wire wr_hw = WR && ADDR == hcer_pkg::OFS_HWSUP;
  wire in_sw = ADDR[4:3] == hcer_pkg::OFS_SWITCHED[4:3];
  wire sw = hwsup_reg[hcer_pkg::BIT_SWITCH];
  wire wr_grp = WR && in_sw;
  wire [2:0] idx = ADDR[2:0];
  wire nv_busy, nv_done;
  wire [63:0] nv_rdata;
  // arming: unlock set on two writes in a row before the store
  wire armed = arm_reg == 2'd2 && unlock_reg;
  // host requests are dropped while an initial recall is pending, so the bank mux
  // never mixes a host store with the jumper-chosen bank
  wire st_go = wr_nv && WDATA[hcer_pkg::BIT_STORE] && armed
    && !nv_busy && !init_pend_reg;
  wire rc_go = wr_nv && WDATA[hcer_pkg::BIT_RECALL] && !st_go
    && !nv_busy && !init_pend_reg;
  wire init_go = init_pend_reg && !nv_busy;
  wire [4:0] init_bank = {1'b0, jmp_s2_reg};
  logic [63:0] addr_flat;
  hcer_pkg::hcer_nvreq_t nvreq;

  // flatten station address for a store
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_flat
      assign addr_flat[g*8 +: 8] = addr_grp[g];
    end
  endgenerate

  assign nvreq.start = st_go || rc_go || init_go;
  assign nvreq.write = st_go;
  assign nvreq.bank = init_go ? init_bank : bank_reg;
  assign nvreq.cfg = init_go;

  // ----------------------------------------------------------------
  // jumper synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    jmp_s1_reg <= INIT_JUMPER_LEVELS;
    jmp_s2_reg <= jmp_s1_reg;
  end

  // ----------------------------------------------------------------
  // control register and engine reset
  // ----------------------------------------------------------------
  // engine reset follows control bit 7 one edge later; reset value keeps it held
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      control_reg <= hcer_pkg::RST_CONTROL;
      engine_reset_reg <= 1'b1;
    end else begin
      if (wr_ctl) control_reg <= {WDATA[7:6], 1'b0, WDATA[4:0]};
      engine_reset_reg <= control_reg[hcer_pkg::BIT_ENG_RESET];
    end
  end

  // ----------------------------------------------------------------
  // nonvolatile control register
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      store_reg <= 1'b0;
      recall_reg <= 1'b0;
      unlock_reg <= 1'b0;
      bank_reg <= hcer_pkg::RST_BANK;
      arm_reg <= 2'd0;
      cfg_dest_reg <= 1'b0;
    end else begin
      if (st_go) store_reg <= 1'b1;
      else if (nv_done) store_reg <= 1'b0;
      if (rc_go) recall_reg <= 1'b1;
      else if (nv_done) recall_reg <= 1'b0;
      if (nvreq.start) cfg_dest_reg <= nvreq.cfg;
      if (wr_nv && !nv_busy) begin
        unlock_reg <= WDATA[hcer_pkg::BIT_UNLOCK];
        // bank taken from every accepted write, recall writes included
        bank_reg <= {WDATA[hcer_pkg::BIT_BANK_TOP], WDATA[3:0]};
        // arm: two consecutive unlock writes; a write without unlock disarms
        if (st_go) arm_reg <= 2'd0;
        else if (WDATA[hcer_pkg::BIT_UNLOCK] && arm_reg != 2'd2)
          arm_reg <= arm_reg + 2'd1;
        else if (!WDATA[hcer_pkg::BIT_UNLOCK]) arm_reg <= 2'd0;
      end
    end
  end

  // ----------------------------------------------------------------
  // switch bit and initial recall
  // ----------------------------------------------------------------
  // jumpers judged once, on the first edge after release; the
  // synchroniser runs through reset, so its output has settled by then
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      hwsup_reg <= hcer_pkg::RST_HWSUP;
      init_pend_reg <= 1'b0;
      init_chk_reg <= 1'b1;
    end else begin
      if (wr_hw) hwsup_reg <= {WDATA[hcer_pkg::BIT_SWITCH], 7'h00};
      // one look only: a later host recall must not start another
      init_chk_reg <= 1'b0;
      if (init_chk_reg && jmp_s2_reg == hcer_pkg::JUMPER_INIT_CODE)
        init_pend_reg <= 1'b1;
      if (init_go) init_pend_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // switched groups
  // ----------------------------------------------------------------
  // recall overwrites target group with the bank's stored values, undefined if never stored
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      for (int i = 0; i < 8; i++) begin
        addr_grp[i] <= 8'h00;
        cfg_grp[i] <= 8'h00;
      end
    end else if (nv_done && !store_reg) begin
      for (int i = 0; i < 8; i++) begin
        if (cfg_dest_reg) cfg_grp[i] <= nv_rdata[i*8 +: 8];
        else addr_grp[i] <= nv_rdata[i*8 +: 8];
      end
    end else if (wr_grp) begin
      if (sw) cfg_grp[idx] <= WDATA;
      else addr_grp[idx] <= WDATA;
    end
  end

  // ----------------------------------------------------------------
  // read mux, registered
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (in_sw) rd_mux = sw ? cfg_grp[idx] : addr_grp[idx];
    else if (ADDR == hcer_pkg::OFS_CONTROL) rd_mux = control_reg;
    else if (ADDR == hcer_pkg::OFS_NVCTL)
      rd_mux = {store_reg, recall_reg, bank_reg[4], unlock_reg,
                jmp_s2_reg};
    else if (ADDR == hcer_pkg::OFS_HWSUP) rd_mux = hwsup_reg;
  end

  wire [15:0] ba_w;
  wire bs_w;
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      rdata_reg <= 8'h00;
      bufaddr_reg <= 16'h0000;
      bufsel_reg <= 1'b0;
    end else begin
      if (RD) rdata_reg <= rd_mux;
      bufaddr_reg <= ba_w;
      bufsel_reg <= bs_w;
    end
  end

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  hcer_nvmem u_nv (
    .clk(MCLK),
    .rst_n(RSTN),
    .req(nvreq),
    .wdata(addr_flat),
    .busy(nv_busy),
    .done(nv_done),
    .rdata(nv_rdata)
  );

  hcer_bufaddr u_ba (
    .host_system_address(HOST_SYSTEM_ADDRESS),
    .base_addr(BUF_BASE),
    .page_offset(control_reg[2:0]),
    .mem_enable(control_reg[hcer_pkg::BIT_MEM_ENABLE]),
    .buf_addr(ba_w),
    .buf_sel(bs_w)
  );

  logic nv_busy_reg, res_reg;
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      nv_busy_reg <= 1'b0;
      res_reg <= 1'b0;
    end else begin
      nv_busy_reg <= nv_busy;
      res_reg <= bank_reg[4];
    end
  end

  assign RDATA = rdata_reg;
  assign BUF_ADDR = bufaddr_reg;
  assign BUF_SEL = bufsel_reg;
  assign ENGINE_RESET = engine_reset_reg;
  assign NV_BUSY = nv_busy_reg;
  assign RESOURCE_AREA = res_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // engine release takes two edges: control bit, then output flop
  sequence s_clear_eng;
    wr_ctl && !WDATA[hcer_pkg::BIT_ENG_RESET];
  endsequence
  chk_eng_release: assert property (
    @(posedge MCLK) disable iff (!RSTN)
    s_clear_eng ##2 1 |-> !ENGINE_RESET)
    else $error("engine reset not released");
  chk_mem_gate: assert property (
    @(posedge MCLK) disable iff (!RSTN)
    BUF_SEL |-> $past(control_reg[hcer_pkg::BIT_MEM_ENABLE]))
    else $error("buffer select without enable");
  chk_store_arm: assert property (
    @(posedge MCLK) disable iff (!RSTN)
    $rose(store_reg) |-> $past(arm_reg) == 2'd2)
    else $error("store without arming");
  chk_busy_ignore: assert property (
    @(posedge MCLK) disable iff (!RSTN)
    nv_busy && !nv_done |=> !$rose(recall_reg))
    else $error("request taken while busy");
  chk_recall_clear: assert property (
    @(posedge MCLK) disable iff (!RSTN)
    $rose(recall_reg) |-> ##[1:300] !recall_reg)
    else $error("recall bit stuck");
  chk_bank_hold: assert property (
    @(posedge MCLK) disable iff (!RSTN)
    !wr_nv |=> $stable(bank_reg))
    else $error("bank changed without write");
  chk_jmp_read: assert property (
    @(posedge MCLK) disable iff (!RSTN)
    RD && ADDR == hcer_pkg::OFS_NVCTL |=>
      RDATA[3:0] == $past(jmp_s2_reg))
    else $error("jumper read wrong");
  chk_reserved_zero: assert property (
    @(posedge MCLK) disable iff (!RSTN)
    !control_reg[5])
    else $error("reserved bit set");
  // initial recall may only be armed in the first cycle after release
  chk_init_once: assert property (
    @(posedge MCLK) disable iff (!RSTN)
    $rose(init_pend_reg) |-> $past(init_chk_reg))
    else $error("initial recall outside reset release");
endmodule : hcer_regs

// ### bench/hcer_host_model.sv
// hcer_host_model: host processor side of the register bank
// assumes: bank samples WR and RD on the rising MCLK edge
`timescale 1ns/1ns
module hcer_host_model (
  // clock
  input wire logic mclk,
  // host register port
  output logic [4:0] addr,
  output logic wr,
  output logic rd,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata,
  // jumper pins and memory address lines
  output logic [3:0] jmp,
  output logic [19:0] host_addr,
  output logic [19:0] buf_base
);
  // ----------------------------------------------------------------
  // idle levels
  // ----------------------------------------------------------------
  initial begin
    addr = 5'h00;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 8'h00;
    jmp = 4'h5; // not the init code, so no recall at first reset
    host_addr = 20'h0C123;
    buf_base = 20'h0C000;
  end

  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  // one write; data and address turn over after the strobe so a
  // decoder that ignores the strobe sees garbage, not the last value
  task automatic bus_write(input logic [4:0] a, input logic [7:0] d);
    @(negedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(negedge mclk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask : bus_write

  // one read; data is taken one and a half cycles after the strobe edge
  task automatic bus_read(input logic [4:0] a, output logic [7:0] d);
    @(negedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(negedge mclk);
    rd <= 1'b0;
    addr <= ~a;
    @(negedge mclk);
    d = rdata;
  endtask : bus_read

  // arming series, then the store request itself
  task automatic arm_store(input logic [4:0] bank);
    logic [7:0] v;
    v = {2'b00, bank[4], 1'b1, bank[3:0]};
    bus_write(hcer_pkg::OFS_NVCTL, v);
    bus_write(hcer_pkg::OFS_NVCTL, v);
    bus_write(hcer_pkg::OFS_NVCTL, v | 8'h80);
  endtask : arm_store
endmodule : hcer_host_model

// ### bench/tb_host_control_eerom_regs.sv
// tb_host_control_eerom_regs: self-checking bench of the register bank
// assumes: host model drives all host pins, bench drives clock and reset
`timescale 1ns/1ns
module tb_host_control_eerom_regs;
  // clock and reset
  logic mclk;
  logic rst_n;
  // host port nets
  logic [4:0] addr;
  logic wr;
  logic rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [3:0] jmp;
  logic [19:0] host_addr;
  logic [19:0] buf_base;
  // bank outputs
  logic [15:0] buf_addr;
  logic buf_sel;
  logic eng_reset;
  logic nv_busy;
  logic res_area;
  // bookkeeping
  int miscompares;
  int checked;
  logic [7:0] d;
  int n;

  // ----------------------------------------------------------------
  // clock, design and host
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  hcer_regs uut (.MCLK(mclk), .RSTN(rst_n), .ADDR(addr), .WR(wr),
    .RD(rd), .WDATA(wdata), .RDATA(rdata), .INIT_JUMPER_LEVELS(jmp),
    .HOST_SYSTEM_ADDRESS(host_addr), .BUF_BASE(buf_base),
    .BUF_ADDR(buf_addr), .BUF_SEL(buf_sel), .ENGINE_RESET(eng_reset),
    .NV_BUSY(nv_busy), .RESOURCE_AREA(res_area));

  hcer_host_model host (.mclk(mclk), .addr(addr), .wr(wr), .rd(rd),
    .wdata(wdata), .rdata(rdata), .jmp(jmp), .host_addr(host_addr),
    .buf_base(buf_base));

  // ----------------------------------------------------------------
  // compare, wait and verdict helpers
  // ----------------------------------------------------------------
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_byte

  task automatic cmp_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_bit

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_word

  // lets registered copies of a write land
  task automatic settle();
    repeat (2) @(negedge mclk);
  endtask : settle

  // bounded wait for the nonvolatile engine to go idle
  task automatic wait_idle();
    n = 0;
    while (nv_busy !== 1'b0 && n < 400) begin
      @(negedge mclk);
      n++;
    end
  endtask : wait_idle

  task automatic results();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  // watchdog: the tests need about 1500 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    results();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    miscompares = 0;
    checked = 0;
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    rst_n <= 1'b1;
    // reset values and live jumper read-back
    host.bus_read(hcer_pkg::OFS_CONTROL, d);
    cmp_byte(d, 8'h80);
    cmp_bit(eng_reset, 1'b1);
    cmp_bit(buf_sel, 1'b0);
    host.bus_read(hcer_pkg::OFS_NVCTL, d);
    cmp_byte(d, 8'h05);
    host.jmp <= 4'hA;
    settle();
    host.bus_read(hcer_pkg::OFS_NVCTL, d);
    cmp_byte(d, 8'h0A);
    // engine reset pulse, memory enable, offset and spare bits
    host.bus_write(hcer_pkg::OFS_CONTROL, 8'h80);
    settle();
    cmp_bit(eng_reset, 1'b1);
    host.bus_write(hcer_pkg::OFS_CONTROL, 8'h5D);
    settle();
    cmp_bit(eng_reset, 1'b0);
    cmp_bit(buf_sel, 1'b1);
    cmp_word(buf_addr, 16'hA123);
    host.bus_read(hcer_pkg::OFS_CONTROL, d);
    cmp_byte(d, 8'h5D);
    host.bus_write(hcer_pkg::OFS_CONTROL, 8'h00);
    settle();
    cmp_bit(buf_sel, 1'b0);
    // station group fill and overlay switching
    for (int i = 0; i < 8; i++) begin
      host.bus_write(5'h08 + 5'(i), 8'hA0 + 8'(i));
    end
    for (int i = 0; i < 8; i++) begin
      host.bus_read(5'h08 + 5'(i), d);
      cmp_byte(d, 8'hA0 + 8'(i));
    end
    host.bus_write(hcer_pkg::OFS_HWSUP, 8'h80);
    host.bus_read(hcer_pkg::OFS_HWSUP, d);
    cmp_byte(d, 8'h80);
    host.bus_write(5'h08, 8'h5A);
    host.bus_read(5'h08, d);
    cmp_byte(d, 8'h5A);
    host.bus_read(hcer_pkg::OFS_CONTROL, d);
    cmp_byte(d, 8'h00);
    host.bus_write(hcer_pkg::OFS_HWSUP, 8'h00);
    host.bus_read(5'h08, d);
    cmp_byte(d, 8'hA0);
    // store without arming is dropped
    host.bus_write(hcer_pkg::OFS_NVCTL, 8'h80);
    settle();
    cmp_bit(nv_busy, 1'b0);
    // armed store, with a refused write in mid-operation
    host.arm_store(5'h00);
    settle();
    cmp_bit(nv_busy, 1'b1);
    host.bus_read(hcer_pkg::OFS_NVCTL, d);
    cmp_bit(d[7], 1'b1);
    host.bus_write(hcer_pkg::OFS_NVCTL, 8'h20);
    settle();
    cmp_bit(res_area, 1'b0);
    wait_idle();
    cmp_bit(nv_busy, 1'b0);
    host.bus_read(hcer_pkg::OFS_NVCTL, d);
    cmp_bit(d[7], 1'b0);
    // clobber the station group, then recall it
    for (int i = 0; i < 8; i++) begin
      host.bus_write(5'h08 + 5'(i), 8'h00);
    end
    host.bus_write(hcer_pkg::OFS_NVCTL, 8'h40);
    settle();
    host.bus_read(hcer_pkg::OFS_NVCTL, d);
    cmp_bit(d[6], 1'b1);
    wait_idle();
    cmp_bit(nv_busy, 1'b0);
    for (int i = 0; i < 8; i++) begin
      host.bus_read(5'h08 + 5'(i), d);
      cmp_byte(d, 8'hA0 + 8'(i));
    end
    // park the station bytes in the bank the init jumpers will pick
    host.arm_store({1'b0, hcer_pkg::JUMPER_INIT_CODE});
    settle();
    cmp_bit(nv_busy, 1'b1);
    wait_idle();
    cmp_bit(nv_busy, 1'b0);
    // bank top bit and a recall write that reloads the same bank
    host.bus_write(hcer_pkg::OFS_NVCTL, 8'h20);
    settle();
    cmp_bit(res_area, 1'b1);
    host.bus_read(hcer_pkg::OFS_NVCTL, d);
    cmp_byte(d, 8'h2A);
    host.bus_write(hcer_pkg::OFS_NVCTL, 8'h60);
    settle();
    wait_idle();
    cmp_bit(res_area, 1'b1);
    host.bus_read(hcer_pkg::OFS_NVCTL, d);
    cmp_byte(d, 8'h2A);
    // second reset with the init code on the jumpers
    host.jmp <= hcer_pkg::JUMPER_INIT_CODE;
    settle();
    rst_n <= 1'b0;
    repeat (2) @(negedge mclk);
    rst_n <= 1'b1;
    n = 0;
    while (nv_busy !== 1'b1 && n < 12) begin
      @(negedge mclk);
      n++;
    end
    cmp_bit(nv_busy, 1'b1);
    wait_idle();
    cmp_bit(nv_busy, 1'b0);
    host.bus_read(hcer_pkg::OFS_NVCTL, d);
    cmp_byte(d, 8'h09);
    // initial recall filled the config group from the jumper bank
    host.bus_write(hcer_pkg::OFS_HWSUP, 8'h80);
    host.bus_read(5'h08, d);
    cmp_byte(d, 8'hA0);
    results();
  end
endmodule : tb_host_control_eerom_regs
